// [ars_defs.svh]
`ifndef ARS_DEFS_SVH
`define ARS_DEFS_SVH

// Model-specific register indices (value held in the counter register)
`define ARS_IDX_CHK_ADDR   32'h0000_0000
`define ARS_IDX_CHK_TYPE   32'h0000_0001
`define ARS_IDX_CACHE_DIS  32'h0000_000E
`define ARS_IDX_CYCLES     32'h0000_0010
`define ARS_IDX_EXT_FEAT   32'hC000_0080
`define ARS_IDX_SYSCALL    32'hC000_0081
`define ARS_IDX_WR_HANDLE  32'hC000_0082
`define ARS_IDX_RANGE_CC   32'hC000_0085
`define ARS_IDX_PWR_EXT    32'hC000_0086
`define ARS_IDX_STATE_OBS  32'hC000_0087
`define ARS_IDX_PAGE_FLUSH 32'hC000_0088
`define ARS_IDX_L2_ACCESS  32'hC000_0089

// Reset values
`define ARS_RST_64         64'h0000_0000_0000_0000
`define ARS_RST_32         32'h0000_0000
`define ARS_RST_16         16'h0000
`define ARS_RST_80         80'h0000_0000_0000_0000_0000
`define ARS_RST_FLAGS      32'h0000_0002
`define ARS_RST_FPU_CTRL   16'h0040
`define ARS_RST_FPU_TAG    16'hFFFF
`define ARS_RST_FETCH      32'h0000_FFF0

// Field positions
`define ARS_CR4_CHK_EN_BIT 6
`define ARS_FLAG_DIR_BIT   10
`define ARS_FLAG_ZERO_BIT  6
`define ARS_FLAG_CARRY_BIT 0
`define ARS_FLAG_SYS_MASK  32'h0003_7300
`define ARS_FLAG_STAT_MASK 32'h0000_08D5
`define ARS_ONE32          32'h0000_0001

`endif

// [ars_pkg.sv]
package ars_pkg;
    // General-register access size
    typedef enum logic [1:0] {
        ARS_SZ_BYTE_LO = 2'h0,
        ARS_SZ_BYTE_HI = 2'h1,
        ARS_SZ_WORD    = 2'h2,
        ARS_SZ_DWORD   = 2'h3
    } ars_size_t;

    // Addressing mode of segment registers
    typedef enum logic {
        ARS_REAL = 1'h0,
        ARS_PROT = 1'h1
    } ars_mode_t;

    // Packed-media element view
    typedef enum logic [1:0] {
        ARS_PK_BYTES = 2'h0,
        ARS_PK_WORDS = 2'h1,
        ARS_PK_DWORD = 2'h2,
        ARS_PK_SREAL = 2'h3
    } ars_pack_t;

    // Model-register access sequence
    typedef enum logic [1:0] {
        ARS_ST_IDLE = 2'b00,
        ARS_ST_ACC  = 2'b01,
        ARS_ST_DONE = 2'b11
    } ars_state_t;
endpackage : ars_pkg

// [ars_regset.sv]
// Operation
// - Six 16-bit segment registers: code, stack, four data.
// - Real mode: segment value shifted gives the segment base.
// - Protected mode: segment value is a descriptor selector.
// - Fetch pointer changes only by advance or control transfer, never direct write.
// - Eight 80-bit float stack registers, numbered 0 to 7.
// - Float status, control and tag words kept.
// - Eight 64-bit packed-media registers alias the float stack.
// - Packed-media integer view: bytes, words or doublewords.
// - Packed-media float view: two single-precision values.
// - General registers hold byte, word and doubleword data.
// - Counter register selects the model register being accessed.
// - Accumulator and io-data registers carry the 64-bit value.
// - Decode indices 0,1,0E,10 and C000_0080-82, C000_0085-89.
// - Eleven registers; low-power builds add C000_0086.
// - No machine-check exception; enable bit and check registers kept.
// - Check registers change only by model write or reset, to zero.
// - Five control registers, numbered 0 to 4.
// - Debug registers 0 to 7, 32 bits; 4 and 5 share layout.
// - Flags: system, direction and status classes.
// - All eight general registers addressable as words and low bytes; high-byte writes only for the lower four.
`timescale 1ns/100ps
`include "ars_defs.svh"
module ars_regset
    import ars_pkg::*;
#(
    parameter bit LOW_POWER = 1'b0
) (
    // Clock and reset
    input  wire logic              i_core_clk,
    input  wire logic              i_sys_rst,
    // General register access
    input  wire logic              i_gpr_we,
    input  wire logic [2:0]        i_gpr_sel,
    input  ars_size_t              i_gpr_size,
    input  wire logic [31:0]       i_gpr_wdata,
    input  wire logic [2:0]        i_gpr_rsel,
    input  ars_size_t              i_gpr_rsize,
    output logic      [31:0]       o_gpr_rdata,
    // Segment registers
    input  wire logic              i_seg_we,
    input  wire logic [2:0]        i_seg_sel,
    input  wire logic [15:0]       i_seg_wdata,
    input  ars_mode_t              i_addr_mode,
    input  wire logic [2:0]        i_seg_rsel,
    output logic      [31:0]       o_seg_base,
    output logic      [15:0]       o_seg_selector,
    // Fetch pointer
    input  wire logic              i_fetch_adv,
    input  wire logic [3:0]        i_fetch_len,
    input  wire logic              i_ctl_xfer,
    input  wire logic [31:0]       i_xfer_target,
    input  wire logic              i_narrow_mode,
    output logic      [31:0]       o_wide_fetch_pointer,
    output logic      [15:0]       o_code_seg,
    // Float stack and packed media
    input  wire logic              i_fp_we,
    input  wire logic [2:0]        i_fp_sel,
    input  wire logic [79:0]       i_fp_wdata,
    input  wire logic              i_pm_we,
    input  wire logic [63:0]       i_pm_wdata,
    input  ars_pack_t              i_pm_view,
    input  wire logic [2:0]        i_pm_elem,
    output logic      [79:0]       o_fp_rdata,
    output logic      [31:0]       o_pm_elem,
    input  wire logic              i_fpw_we,
    input  wire logic [1:0]        i_fpw_sel,
    input  wire logic [15:0]       i_fpw_wdata,
    output logic      [15:0]       o_fpu_status,
    output logic      [15:0]       o_fpu_control,
    output logic      [15:0]       o_fpu_tag,
    // Flags, control and debug registers
    input  wire logic              i_flags_we,
    input  wire logic [31:0]       i_flags_wdata,
    input  wire logic              i_stat_we,
    input  wire logic [31:0]       i_stat_wdata,
    output logic      [31:0]       o_flags_reg,
    output logic                   o_dir_flag,
    input  wire logic              i_cr_we,
    input  wire logic [2:0]        i_cr_sel,
    input  wire logic              i_dr_we,
    input  wire logic [2:0]        i_dr_sel,
    input  wire logic [31:0]       i_sys_wdata,
    output logic      [31:0]       o_cr_rdata,
    output logic      [31:0]       o_dr_rdata,
    output logic                   o_check_fault_enable_bit,
    // Model-register instructions
    input  wire logic              i_model_reg_read_instr,
    input  wire logic              i_model_reg_write_instr,
    output logic                   o_model_done,
    output logic                   o_gp_fault
);
    logic [31:0] gpr_ff [8];
    logic [15:0] seg_ff [6];
    logic [31:0] fetch_ff;
    logic [79:0] fpr_ff [8];
    logic [15:0] fsw_ff, fcw_ff, ftw_ff;
    logic [31:0] flags_ff;
    logic [31:0] cr_ff [5];
    logic [31:0] dr_ff [8];
    logic [63:0] msr_ff [12];
    ars_state_t  state_ff;
    logic        is_wr_ff;
    logic [3:0]  slot_ff;
    logic        hit_ff;

    // Index decode: slot number per model register
    logic [3:0]  nxt_slot;
    logic        nxt_hit;
    always_comb begin
        nxt_hit  = 1'b1;
        case (gpr_ff[1])
            `ARS_IDX_CHK_ADDR:   nxt_slot = 4'h0;
            `ARS_IDX_CHK_TYPE:   nxt_slot = 4'h1;
            `ARS_IDX_CACHE_DIS:  nxt_slot = 4'h2;
            `ARS_IDX_CYCLES:     nxt_slot = 4'h3;
            `ARS_IDX_EXT_FEAT:   nxt_slot = 4'h4;
            `ARS_IDX_SYSCALL:    nxt_slot = 4'h5;
            `ARS_IDX_WR_HANDLE:  nxt_slot = 4'h6;
            `ARS_IDX_RANGE_CC:   nxt_slot = 4'h7;
            `ARS_IDX_STATE_OBS:  nxt_slot = 4'h8;
            `ARS_IDX_PAGE_FLUSH: nxt_slot = 4'h9;
            `ARS_IDX_L2_ACCESS:  nxt_slot = 4'hA;
            `ARS_IDX_PWR_EXT: begin
                nxt_slot = 4'hB;
                nxt_hit  = LOW_POWER;
            end
            default: begin
                nxt_slot = 4'h0;
                nxt_hit  = 1'b0;
            end
        endcase
    end

    // Model-register access sequence
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_ff <= ARS_ST_IDLE;
            is_wr_ff <= 1'b0;
            slot_ff  <= 4'h0;
            hit_ff   <= 1'b0;
        end else begin
            case (state_ff)
                ARS_ST_IDLE: begin
                    if (i_model_reg_read_instr || i_model_reg_write_instr) begin
                        state_ff <= ARS_ST_ACC;
                        is_wr_ff <= i_model_reg_write_instr;
                        slot_ff  <= nxt_slot;
                        hit_ff   <= nxt_hit;
                    end
                end
                ARS_ST_ACC:  state_ff <= ARS_ST_DONE;
                ARS_ST_DONE: state_ff <= ARS_ST_IDLE;
                default:     state_ff <= ARS_ST_IDLE;
            endcase
        end
    end

    wire acc_cyc = (state_ff == ARS_ST_ACC);

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_model_done <= 1'b0;
            o_gp_fault   <= 1'b0;
        end else begin
            o_model_done <= acc_cyc;
            o_gp_fault   <= acc_cyc && !hit_ff;
        end
    end

    // Model registers; cycle counter advances every clock it is not model-written
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int i = 0; i < 12; i++) begin
                msr_ff[i] <= `ARS_RST_64;
            end
        end else begin
            msr_ff[3] <= msr_ff[3] + 64'h1;
            if (acc_cyc && is_wr_ff && hit_ff) begin
                msr_ff[slot_ff] <= {gpr_ff[2], gpr_ff[0]};
            end
        end
    end

    // General registers, with size-overlaid writes
    logic [31:0] nxt_gpr;
    always_comb begin
        nxt_gpr = gpr_ff[i_gpr_sel];
        case (i_gpr_size)
            ARS_SZ_BYTE_LO: nxt_gpr[7:0]  = i_gpr_wdata[7:0];
            ARS_SZ_BYTE_HI: nxt_gpr[15:8] = i_gpr_wdata[7:0];
            ARS_SZ_WORD:    nxt_gpr[15:0] = i_gpr_wdata[15:0];
            default:        nxt_gpr       = i_gpr_wdata;
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int i = 0; i < 8; i++) begin
                gpr_ff[i] <= `ARS_RST_32;
            end
        end else if (acc_cyc && !is_wr_ff && hit_ff) begin
            gpr_ff[0] <= msr_ff[slot_ff][31:0];
            gpr_ff[2] <= msr_ff[slot_ff][63:32];
        end else if (i_gpr_we && !(i_gpr_sel[2] && i_gpr_size == ARS_SZ_BYTE_HI)) begin
            gpr_ff[i_gpr_sel] <= nxt_gpr; // High bytes exist only for lower four
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_gpr_rdata <= `ARS_RST_32;
        end else begin
            case (i_gpr_rsize)
                ARS_SZ_BYTE_LO: o_gpr_rdata <= {24'h00_0000, gpr_ff[i_gpr_rsel][7:0]};
                ARS_SZ_BYTE_HI: o_gpr_rdata <= {24'h00_0000, gpr_ff[i_gpr_rsel][15:8]};
                ARS_SZ_WORD:    o_gpr_rdata <= {16'h0000, gpr_ff[i_gpr_rsel][15:0]};
                default:        o_gpr_rdata <= gpr_ff[i_gpr_rsel];
            endcase
        end
    end

    // Segment registers: 0 code, 1 stack, 2-5 data
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int i = 0; i < 6; i++) begin
                seg_ff[i] <= `ARS_RST_16;
            end
        end else if (i_seg_we && i_seg_sel < 3'd6) begin
            seg_ff[i_seg_sel] <= i_seg_wdata;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_seg_base     <= `ARS_RST_32;
            o_seg_selector <= `ARS_RST_16;
            o_code_seg     <= `ARS_RST_16;
        end else begin
            o_code_seg <= seg_ff[0];
            if (i_seg_rsel >= 3'd6) begin
                o_seg_base     <= `ARS_RST_32;
                o_seg_selector <= `ARS_RST_16;
            end else if (i_addr_mode == ARS_REAL) begin
                o_seg_base     <= {12'h000, seg_ff[i_seg_rsel], 4'h0};
                o_seg_selector <= `ARS_RST_16;
            end else begin
                // Descriptor lookup happens outside; only the selector leaves here
                o_seg_base     <= `ARS_RST_32;
                o_seg_selector <= seg_ff[i_seg_rsel];
            end
        end
    end

    // Fetch pointer: no write port, only advance or transfer
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            fetch_ff <= `ARS_RST_FETCH;
        end else if (i_ctl_xfer) begin
            fetch_ff <= i_narrow_mode ? {16'h0000, i_xfer_target[15:0]}
                                      : i_xfer_target;
        end else if (i_fetch_adv) begin
            fetch_ff <= i_narrow_mode ? {16'h0000, fetch_ff[15:0] + {12'h000, i_fetch_len}}
                                      : fetch_ff + {28'h000_0000, i_fetch_len};
        end
    end
    assign o_wide_fetch_pointer = fetch_ff;

    // Float stack; packed-media writes land in the mantissa, exponent set all-ones
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int i = 0; i < 8; i++) begin
                fpr_ff[i] <= `ARS_RST_80;
            end
        end else if (i_pm_we) begin
            fpr_ff[i_fp_sel] <= {16'hFFFF, i_pm_wdata};
        end else if (i_fp_we) begin
            fpr_ff[i_fp_sel] <= i_fp_wdata;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_fp_rdata <= `ARS_RST_80;
            o_pm_elem  <= `ARS_RST_32;
        end else begin
            o_fp_rdata <= fpr_ff[i_fp_sel];
            case (i_pm_view)
                ARS_PK_BYTES: o_pm_elem <= {24'h00_0000,
                                            fpr_ff[i_fp_sel][i_pm_elem*8 +: 8]};
                ARS_PK_WORDS: o_pm_elem <= {16'h0000,
                                            fpr_ff[i_fp_sel][i_pm_elem[1:0]*16 +: 16]};
                ARS_PK_DWORD: o_pm_elem <= fpr_ff[i_fp_sel][i_pm_elem[0]*32 +: 32];
                default:      o_pm_elem <= fpr_ff[i_fp_sel][i_pm_elem[0]*32 +: 32];
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            fsw_ff <= `ARS_RST_16;
            fcw_ff <= `ARS_RST_FPU_CTRL;
            ftw_ff <= `ARS_RST_FPU_TAG;
        end else if (i_fpw_we) begin
            case (i_fpw_sel)
                2'h0:    fsw_ff <= i_fpw_wdata;
                2'h1:    fcw_ff <= i_fpw_wdata;
                2'h2:    ftw_ff <= i_fpw_wdata;
                default: fsw_ff <= fsw_ff;
            endcase
        end
    end
    assign o_fpu_status  = fsw_ff;
    assign o_fpu_control = fcw_ff;
    assign o_fpu_tag     = ftw_ff;

    // Flags: full write, or status-class update from the execution units
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            flags_ff <= `ARS_RST_FLAGS;
        end else if (i_flags_we) begin
            flags_ff <= i_flags_wdata | `ARS_RST_FLAGS;
        end else if (i_stat_we) begin
            flags_ff <= (flags_ff & ~`ARS_FLAG_STAT_MASK)
                      | (i_stat_wdata & `ARS_FLAG_STAT_MASK);
        end
    end
    assign o_flags_reg = flags_ff;
    assign o_dir_flag  = flags_ff[`ARS_FLAG_DIR_BIT];

    // Control and debug registers; index 5 of debug folds onto 4
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int i = 0; i < 5; i++) begin
                cr_ff[i] <= `ARS_RST_32;
            end
            for (int i = 0; i < 8; i++) begin
                dr_ff[i] <= `ARS_RST_32;
            end
            o_cr_rdata <= `ARS_RST_32;
            o_dr_rdata <= `ARS_RST_32;
        end else begin
            if (i_cr_we && i_cr_sel < 3'd5) begin
                cr_ff[i_cr_sel] <= i_sys_wdata;
            end
            if (i_dr_we) begin
                dr_ff[(i_dr_sel == 3'd5) ? 3'd4 : i_dr_sel] <= i_sys_wdata;
            end
            o_cr_rdata <= (i_cr_sel < 3'd5) ? cr_ff[i_cr_sel] : `ARS_RST_32;
            o_dr_rdata <= dr_ff[(i_dr_sel == 3'd5) ? 3'd4 : i_dr_sel];
        end
    end
    // Enable bit is kept, but nothing raises a check exception
    assign o_check_fault_enable_bit = cr_ff[4][`ARS_CR4_CHK_EN_BIT];

    // Assertions
    chk_reset_zero_a: assert property (@(posedge i_core_clk)
        $fell(i_sys_rst) |-> (msr_ff[0] == `ARS_RST_64 && msr_ff[1] == `ARS_RST_64))
        else $error("check registers not cleared by reset");
    chk_stable_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        !(acc_cyc && is_wr_ff) |=> $stable(msr_ff[0]) && $stable(msr_ff[1]))
        else $error("check register changed without model write");
    fault_unmatched_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (state_ff == ARS_ST_IDLE && (i_model_reg_read_instr || i_model_reg_write_instr)
         && !nxt_hit) |-> ##2 o_gp_fault)
        else $error("unmatched index did not fault");
    pwr_ext_gate_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (gpr_ff[1] == `ARS_IDX_PWR_EXT) |-> (nxt_hit == LOW_POWER))
        else $error("power extension decode wrong for build");
    read_load_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (acc_cyc && !is_wr_ff && hit_ff && !i_gpr_we) |=>
            gpr_ff[0] == $past(msr_ff[slot_ff][31:0]))
        else $error("accumulator not loaded by model read");
    fetch_nowrite_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (!i_ctl_xfer && !i_fetch_adv) |=> $stable(fetch_ff))
        else $error("fetch pointer changed without transfer");
    cycles_run_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        !i_sys_rst && !(acc_cyc && is_wr_ff && slot_ff == 4'h3) |=>
            msr_ff[3] == $past(msr_ff[3]) + 64'h1)
        else $error("cycle counter did not advance");
    done_fault_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        o_gp_fault |-> o_model_done)
        else $error("fault without completion");
endmodule : ars_regset

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top
    import ars_pkg::*;
();
    // Stimulus
    logic        i_core_clk, i_sys_rst, i_gpr_we, i_seg_we, i_fetch_adv, i_ctl_xfer;
    logic        i_narrow_mode, i_fp_we, i_pm_we, i_fpw_we, i_flags_we, i_stat_we, i_cr_we;
    logic        i_dr_we, i_model_reg_read_instr, i_model_reg_write_instr;
    logic [2:0]  i_gpr_sel, i_gpr_rsel, i_seg_sel, i_seg_rsel, i_fp_sel, i_pm_elem;
    logic [2:0]  i_cr_sel, i_dr_sel;
    logic [1:0]  i_fpw_sel;
    logic [3:0]  i_fetch_len;
    logic [15:0] i_seg_wdata, i_fpw_wdata;
    logic [31:0] i_gpr_wdata, i_xfer_target, i_flags_wdata, i_stat_wdata, i_sys_wdata;
    logic [63:0] i_pm_wdata;
    logic [79:0] i_fp_wdata;
    ars_size_t   i_gpr_size, i_gpr_rsize;
    ars_mode_t   i_addr_mode;
    ars_pack_t   i_pm_view;
    // Observed
    logic        o_dir_flag, o_check_fault_enable_bit, o_model_done, o_gp_fault;
    logic [15:0] o_seg_selector, o_code_seg, o_fpu_status, o_fpu_control, o_fpu_tag;
    logic [31:0] o_gpr_rdata, o_seg_base, o_wide_fetch_pointer, o_pm_elem, o_flags_reg;
    logic [31:0] o_cr_rdata, o_dr_rdata;
    logic [79:0] o_fp_rdata;
    // Reference model
    int          bad_count, num_checks, cycles;
    logic [31:0] gm [8];
    logic [63:0] mm [logic [31:0]];
    logic [31:0] ok_idx [10] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_000E, 32'hC000_0080,
        32'hC000_0081, 32'hC000_0082, 32'hC000_0085, 32'hC000_0087, 32'hC000_0088, 32'hC000_0089};
    logic [31:0] bad_idx [5] = '{32'h0000_0002, 32'h0000_0011, 32'hC000_0083, 32'hC000_0086,
        32'hC000_008A};

    ars_regset #(.LOW_POWER(1'b0)) u_dut (.*);

    always #12.5 i_core_clk = ~i_core_clk;

    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic complete_run;
        if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic settle;
        @(posedge i_core_clk);
        #1;
    endtask : settle

    task automatic mdl_reset;
        foreach (gm[k]) gm[k] = '0;
        foreach (mm[k]) mm[k] = '0;
    endtask : mdl_reset

    task automatic gw(input int s, input int z, input logic [31:0] d);
        @(posedge i_core_clk);
        i_gpr_we    <= 1'b1;
        i_gpr_sel   <= 3'(s);
        i_gpr_size  <= ars_size_t'(z);
        i_gpr_wdata <= d;
        @(posedge i_core_clk);
        i_gpr_we    <= 1'b0;
        if (z == 0) gm[s][7:0] = d[7:0];
        else if (z == 1) gm[s][15:8] = d[7:0];
        else if (z == 2) gm[s][15:0] = d[15:0];
        else gm[s] = d;
    endtask : gw

    task automatic gr(input int s, input int z);
        logic [31:0] e;
        e = (gm[s] >> ((z == 1) ? 8 : 0)) & ((z == 2) ? 32'h0000_FFFF : 32'h0000_00FF);
        if (z == 3) e = gm[s];
        @(posedge i_core_clk);
        i_gpr_rsel  <= 3'(s);
        i_gpr_rsize <= ars_size_t'(z);
        settle();
        chk(o_gpr_rdata, e);
    endtask : gr

    task automatic model_specific_reg(input logic wr, input logic [31:0] idx);
        int   n;
        logic bad;
        bad = !mm.exists(idx);
        gw(1, 3, idx);
        @(posedge i_core_clk);
        i_model_reg_write_instr <= wr;
        i_model_reg_read_instr  <= !wr;
        @(posedge i_core_clk);
        i_model_reg_write_instr <= 1'b0;
        i_model_reg_read_instr  <= 1'b0;
        for (n = 1; n < 6; n++) begin
            settle();
            if (o_model_done === 1'b1) break;
        end
        chk(n, 1);
        chk(o_gp_fault, bad);
        if (!bad && wr) mm[idx] = {gm[2], gm[0]};
        if (!bad && !wr) {gm[2], gm[0]} = mm[idx];
    endtask : model_specific_reg

    initial begin
        logic [31:0] t, tg;
        logic [63:0] d;
        logic [79:0] fm [8];
        logic [31:0] cm [13];
        logic [15:0] s0;
        int          w;
        {i_core_clk, i_gpr_we, i_seg_we, i_fetch_adv, i_ctl_xfer, i_narrow_mode, i_fp_we,
         i_pm_we, i_fpw_we, i_flags_we, i_stat_we, i_cr_we, i_dr_we, i_model_reg_read_instr,
         i_model_reg_write_instr, i_gpr_sel, i_gpr_rsel, i_seg_sel, i_seg_rsel, i_fp_sel,
         i_pm_elem, i_cr_sel, i_dr_sel, i_fpw_sel, i_fetch_len, i_seg_wdata, i_fpw_wdata,
         i_gpr_wdata, i_xfer_target, i_flags_wdata, i_stat_wdata, i_sys_wdata, i_pm_wdata,
         i_fp_wdata} = '0;
        i_sys_rst   = 1'b1;
        i_gpr_size  = ARS_SZ_DWORD;
        i_gpr_rsize = ARS_SZ_DWORD;
        i_addr_mode = ARS_REAL;
        i_pm_view   = ARS_PK_BYTES;
        tg = $urandom(32'hc10f_9e0c);
        foreach (ok_idx[k]) mm[ok_idx[k]] = '0;
        mm[32'h0000_0010] = '0;
        mdl_reset();
        repeat (6) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        settle();
        chk(o_flags_reg, 32'h0000_0002);
        chk({o_fpu_tag, o_fpu_control, o_fpu_status}, 48'hFFFF_0040_0000);
        chk(o_wide_fetch_pointer, 32'h0000_FFF0);
        @(posedge i_core_clk);
        i_fetch_adv <= 1'b1;
        i_fetch_len <= 4'h9;
        @(posedge i_core_clk);
        i_fetch_adv   <= 1'b0;
        i_ctl_xfer    <= 1'b1;
        i_xfer_target <= tg;
        #1;
        chk(o_wide_fetch_pointer, 32'h0000_FFF9);
        @(posedge i_core_clk);
        {i_ctl_xfer, i_fetch_adv, i_narrow_mode} <= 3'b011;
        #1;
        chk(o_wide_fetch_pointer, tg);
        tg = {16'h0000, tg[15:0] + 16'h0009};
        @(posedge i_core_clk);
        {i_fetch_adv, i_narrow_mode} <= 2'b00;
        for (int r = 0; r < 8; r++) begin
            for (int z = 0; z < 4; z++) begin
                if (r > 3 && z < 2) continue;
                t = $urandom;
                gw(r, z, t);
                for (int q = 0; q < 4; q++) if (r < 4 || q > 1) gr(r, q);
            end
        end
        for (int k = 0; k < 6; k++) begin
            t = $urandom;
            if (k == 0) s0 = t[15:0];
            @(posedge i_core_clk);
            i_seg_we    <= 1'b1;
            i_seg_sel   <= 3'(k);
            i_seg_wdata <= t[15:0];
            @(posedge i_core_clk);
            i_seg_we    <= 1'b0;
            i_seg_rsel  <= 3'(k);
            i_addr_mode <= ARS_REAL;
            @(posedge i_core_clk);
            i_addr_mode <= ARS_PROT;
            #1;
            chk({o_seg_base, o_seg_selector}, {12'h000, t[15:0], 20'h0_0000});
            settle();
            chk({o_seg_base, o_seg_selector}, {32'h0000_0000, t[15:0]});
        end
        chk(o_code_seg, s0);
        for (int k = 0; k < 8; k++) begin
            fm[k] = {16'($urandom), $urandom, $urandom};
            @(posedge i_core_clk);
            i_fp_we    <= 1'b1;
            i_fp_sel   <= 3'(k);
            i_fp_wdata <= fm[k];
        end
        d = {$urandom, $urandom};
        fm[3] = {16'hFFFF, d};
        @(posedge i_core_clk);
        i_fp_we    <= 1'b0;
        i_pm_we    <= 1'b1;
        i_fp_sel   <= 3'h3;
        i_pm_wdata <= d;
        @(posedge i_core_clk);
        i_pm_we <= 1'b0;
        for (int k = 0; k < 8; k++) begin
            @(posedge i_core_clk);
            i_fp_sel <= 3'(k);
            settle();
            chk(o_fp_rdata, fm[k]);
        end
        for (int v = 0; v < 4; v++) begin
            w = (v == 3) ? 32 : (8 << v);
            for (int e = 0; e < 64 / w; e++) begin
                @(posedge i_core_clk);
                i_fp_sel  <= 3'h3;
                i_pm_view <= ars_pack_t'(v);
                i_pm_elem <= 3'(e);
                settle();
                chk(o_pm_elem, (d >> (e * w)) & ((64'h1 << w) - 64'h1));
            end
        end
        for (int k = 0; k < 3; k++) begin
            t = $urandom;
            @(posedge i_core_clk);
            i_fpw_we    <= 1'b1;
            i_fpw_sel   <= 2'(k);
            i_fpw_wdata <= t[15:0];
            @(posedge i_core_clk);
            i_fpw_we <= 1'b0;
            #1;
            chk(16'({o_fpu_tag, o_fpu_control, o_fpu_status} >> (16 * k)), t[15:0]);
        end
        t = $urandom;
        @(posedge i_core_clk);
        i_flags_we    <= 1'b1;
        i_flags_wdata <= t;
        @(posedge i_core_clk);
        i_flags_we   <= 1'b0;
        i_stat_we    <= 1'b1;
        i_stat_wdata <= ~t;
        #1;
        chk({o_dir_flag, o_flags_reg}, {t[10], t | 32'h0000_0002});
        @(posedge i_core_clk);
        i_stat_we <= 1'b0;
        #1;
        chk(o_flags_reg, (t ^ 32'h0000_08D5) | 32'h0000_0002);
        for (int k = 0; k < 13; k++) begin
            cm[k] = $urandom;
            @(posedge i_core_clk);
            i_cr_we     <= (k < 5);
            i_dr_we     <= (k > 4);
            i_cr_sel    <= 3'(k);
            i_dr_sel    <= 3'(k - 5);
            i_sys_wdata <= cm[k];
        end
        @(posedge i_core_clk);
        i_cr_we <= 1'b0;
        i_dr_we <= 1'b0;
        #1;
        chk(o_check_fault_enable_bit, cm[4][6]);
        for (int k = 0; k < 13; k++) begin
            @(posedge i_core_clk);
            i_cr_sel <= 3'(k);
            i_dr_sel <= 3'(k - 5);
            settle();
            chk((k < 5) ? o_cr_rdata : o_dr_rdata, cm[(k == 9) ? 10 : k]);
        end
        foreach (ok_idx[k]) begin
            gw(0, 3, $urandom);
            gw(2, 3, $urandom);
            model_specific_reg(1'b1, ok_idx[k]);
        end
        foreach (bad_idx[k]) begin
            gw(0, 3, $urandom);
            model_specific_reg(1'b1, bad_idx[k]);
            model_specific_reg(1'b0, bad_idx[k]);
            gr(0, 3);
            gr(2, 3);
        end
        foreach (ok_idx[k]) begin
            model_specific_reg(1'b0, ok_idx[k]);
            gr(0, 3);
            gr(2, 3);
        end
        chk(o_wide_fetch_pointer, tg);
        // Free-running counter: only a bounded advance can be predicted
        gw(0, 3, 32'h0000_0100);
        gw(2, 3, 32'h0000_0000);
        model_specific_reg(1'b1, 32'h0000_0010);
        model_specific_reg(1'b0, 32'h0000_0010);
        gr(2, 3);
        @(posedge i_core_clk);
        i_gpr_rsel <= 3'h0;
        settle();
        chk((o_gpr_rdata - 32'h0000_0100) inside {[1:40]}, 1'b1);
        @(posedge i_core_clk);
        i_sys_rst <= 1'b1;
        repeat (6) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        mdl_reset();
        for (int k = 0; k < 2; k++) begin
            model_specific_reg(1'b0, ok_idx[k]);
            gr(0, 3);
            gr(2, 3);
        end
        complete_run();
    end
endmodule : tb_top
